// file: ufl_top.sv
// Serial channel with FIFOs, trigger tables and line format, APB slave
`default_nettype none
module ufl_top (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_in,
	output logic tx_out,
	output logic irq
);
	// ------------------------------------------------------------------
	// Parity helper
	// ------------------------------------------------------------------
	function automatic logic par_of(input logic [7:0] d,
		input ufl_pkg::ufl_fmt_t f);
		logic x;
		x = ^d;
		if (f.force_par)
			par_of = ~f.even; // [RL8]
		else
			par_of = f.even ? x : ~x; // [RL9]
	endfunction

	function automatic logic [7:0] wl_mask(input logic [1:0] wl);
		wl_mask = 8'hff >> (3'h3 - {1'b0, wl});
	endfunction

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic pready_r, pslverr_r, tx_out_r, irq_r;
	logic [31:0] prdata_r;
	logic fifo_en_r;
	logic [1:0] rx_code_r, tx_code_r;
	logic [7:0] feat_r, lcr_r, div_lo_r, div_hi_r, div_fr_r;
	logic [6:0] rx_trig_reg_r, tx_trig_reg_r;
	localparam int IRQ_N_W = ufl_pkg::IRQ_N;
	logic [IRQ_N_W-1:0] irq_stat_r, irq_en_r;

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	wire acc = psel & penable & ~pready_r;
	wire wr = acc & pwrite;
	wire rd = acc & ~pwrite;
	wire dlab = lcr_r[ufl_pkg::LC_DLAB];
	wire a_data = paddr == ufl_pkg::ADDR_DATA;
	wire a_feat = paddr == ufl_pkg::ADDR_FEAT;
	wire a_fifo = paddr == ufl_pkg::ADDR_FIFO;
	wire a_line = paddr == ufl_pkg::ADDR_LINE;
	wire a_rxtg = paddr == ufl_pkg::ADDR_RXTRIG;
	wire a_txtg = paddr == ufl_pkg::ADDR_TXTRIG;
	wire a_stat = paddr == ufl_pkg::ADDR_STAT;
	wire a_ist = paddr == ufl_pkg::ADDR_IRQ_STAT;
	wire a_icl = paddr == ufl_pkg::ADDR_IRQ_CLR;
	wire a_ien = paddr == ufl_pkg::ADDR_IRQ_EN;
	wire mapped = a_data | a_feat | a_fifo | a_line | a_rxtg | a_txtg
		| a_stat | a_ist | a_icl | a_ien;
	// Same addresses reach divisors while the access bit is set
	wire w_thr = wr & a_data & ~dlab; // [RL6]
	wire r_rhr = rd & a_data & ~dlab; // [RL6]
	wire w_dll = wr & a_data & dlab; // [RL6]
	wire w_dlm = wr & a_feat & dlab; // [RL6]
	wire w_dld = wr & a_fifo & dlab; // [RL6]
	wire w_feat = wr & a_feat & ~dlab;
	wire w_fcr = wr & a_fifo & ~dlab;
	wire fcr_en = pwdata[ufl_pkg::FC_EN];
	wire rx_rst = w_fcr & fcr_en & pwdata[ufl_pkg::FC_RXRST]; // [RL14]
	wire tx_rst = w_fcr & fcr_en & pwdata[ufl_pkg::FC_TXRST]; // [RL14]

	// ------------------------------------------------------------------
	// Line format and trigger decode
	// ------------------------------------------------------------------
	ufl_pkg::ufl_fmt_t fmt;
	assign fmt.pen = lcr_r[ufl_pkg::LC_PEN];
	assign fmt.even = lcr_r[ufl_pkg::LC_EVEN];
	assign fmt.force_par = lcr_r[ufl_pkg::LC_FORCE];
	assign fmt.two_stop = lcr_r[ufl_pkg::LC_STOP];
	assign fmt.wl = lcr_r[1:0]; // [RL12]
	wire [3:0] nbits = 4'h5 + {2'b00, fmt.wl}; // [RL12]
	wire [4:0] stop_half = ~fmt.two_stop ? ufl_pkg::STOP_HALF_1 :
		(fmt.wl == 2'b00) ? ufl_pkg::STOP_HALF_15 :
		ufl_pkg::STOP_HALF_2; // [RL11]
	wire [1:0] tbl = feat_r[7:6]; // [RL13]
	wire [6:0] rx_trig = (tbl == ufl_pkg::TBL_A) ?
		ufl_pkg::RX_TBL_A[rx_code_r] : // [RL3]
		(tbl == ufl_pkg::TBL_B) ? ufl_pkg::RX_TBL_B[rx_code_r] :
		(tbl == ufl_pkg::TBL_C) ? ufl_pkg::RX_TBL_C[rx_code_r] : // [RL4]
		rx_trig_reg_r; // [RL5]
	wire [6:0] tx_trig = (tbl == ufl_pkg::TBL_A) ? ufl_pkg::TRIG_ONE :
		(tbl == ufl_pkg::TBL_B) ? ufl_pkg::TX_TBL_B[tx_code_r] : // [RL3]
		(tbl == ufl_pkg::TBL_C) ? ufl_pkg::TX_TBL_C[tx_code_r] : // [RL4]
		tx_trig_reg_r; // [RL5]
	// Without FIFOs each side is a one-character holding register
	wire [6:0] cap = fifo_en_r ? ufl_pkg::FIFO_CAP : ufl_pkg::HOLD_CAP;
	wire [6:0] rx_trig_eff = fifo_en_r ? rx_trig : ufl_pkg::TRIG_ONE;
	wire [6:0] tx_trig_eff = fifo_en_r ? tx_trig : ufl_pkg::TRIG_ONE;
	wire [15:0] divisor = {div_hi_r, div_lo_r};
	wire [14:0] half_div = (divisor[15:1] == 15'h0000) ? 15'h0001 :
		divisor[15:1];

	// ------------------------------------------------------------------
	// FIFO storage
	// ------------------------------------------------------------------
	ufl_pkg::ufl_rx_entry_t rx_mem [ufl_pkg::FIFO_DEPTH];
	logic [7:0] tx_mem [ufl_pkg::FIFO_DEPTH];
	logic [5:0] rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
	logic [6:0] rx_lvl_r, tx_lvl_r;
	logic rx_done, rx_push_ok;
	ufl_pkg::ufl_rx_entry_t rx_entry;
	wire rx_push = rx_done & rx_push_ok;
	wire rx_pop = r_rhr & (rx_lvl_r != 7'h00);
	assign rx_push_ok = rx_lvl_r < cap;
	wire tx_push = w_thr & (tx_lvl_r < cap);
	logic tx_busy_r;
	wire tx_pop = ~tx_busy_r & (tx_lvl_r != 7'h00);
	wire [6:0] rx_lvl_nxt = rx_lvl_r + {6'h00, rx_push} - {6'h00, rx_pop};
	wire [6:0] tx_lvl_nxt = tx_lvl_r + {6'h00, tx_push} - {6'h00, tx_pop};
	ufl_pkg::ufl_rx_entry_t rx_head;
	assign rx_head = rx_mem[rx_rp_r];

	always_ff @(posedge sys_clk)
	begin
		if (ce && rx_push)
			rx_mem[rx_wp_r] <= rx_entry;
		if (ce && tx_push)
			tx_mem[tx_wp_r] <= pwdata[7:0] & wl_mask(fmt.wl);
	end

	// Pointer and level reset leaves the shift registers alone
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_wp_r <= 6'h00;
			rx_rp_r <= 6'h00;
			rx_lvl_r <= 7'h00;
		end
		else if (ce && rx_rst)
		begin
			rx_wp_r <= 6'h00; // [RL14]
			rx_rp_r <= 6'h00;
			rx_lvl_r <= 7'h00;
		end
		else if (ce)
		begin
			rx_wp_r <= rx_wp_r + {5'h00, rx_push};
			rx_rp_r <= rx_rp_r + {5'h00, rx_pop};
			rx_lvl_r <= rx_lvl_nxt;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tx_wp_r <= 6'h00;
			tx_rp_r <= 6'h00;
			tx_lvl_r <= 7'h00;
		end
		else if (ce && tx_rst)
		begin
			tx_wp_r <= 6'h00; // [RL14]
			tx_rp_r <= 6'h00;
			tx_lvl_r <= 7'h00;
		end
		else if (ce)
		begin
			tx_wp_r <= tx_wp_r + {5'h00, tx_push};
			tx_rp_r <= tx_rp_r + {5'h00, tx_pop};
			tx_lvl_r <= tx_lvl_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Transmitter: frame shifted once per bit, timed in half-bit steps for 1.5 stop bits
	// ------------------------------------------------------------------
	logic [11:0] tx_frame_r;
	logic [4:0] tx_half_r;
	logic [14:0] tx_tick_r;
	logic tx_phase_r;
	logic [11:0] frame_nxt;
	logic [7:0] tx_byte;
	assign tx_byte = tx_mem[tx_rp_r];
	wire [4:0] data_half = {nbits + {3'b000, fmt.pen} + 4'h1, 1'b0};
	wire tx_tick = tx_tick_r == 15'h0001;

	always_comb
	begin
		frame_nxt = 12'hfff;
		frame_nxt[0] = 1'b0;
		frame_nxt[8:1] = tx_byte | ~wl_mask(fmt.wl);
		if (fmt.pen)
			frame_nxt[nbits + 4'h1] = par_of(tx_byte, fmt); // [RL10]
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			tx_frame_r <= 12'hfff;
			tx_half_r <= 5'h00;
			tx_tick_r <= 15'h0001;
			tx_phase_r <= 1'b0;
			tx_busy_r <= 1'b0;
		end
		else if (ce && tx_pop)
		begin
			tx_frame_r <= frame_nxt;
			tx_half_r <= data_half + stop_half; // [RL11]
			tx_tick_r <= half_div;
			tx_phase_r <= 1'b0;
			tx_busy_r <= 1'b1;
		end
		else if (ce && tx_busy_r)
		begin
			tx_tick_r <= tx_tick ? half_div : tx_tick_r - 15'h0001;
			if (tx_tick)
			begin
				tx_phase_r <= ~tx_phase_r;
				tx_half_r <= tx_half_r - 5'h01;
				if (tx_phase_r)
					tx_frame_r <= {1'b1, tx_frame_r[11:1]};
				if (tx_half_r == 5'h01)
					tx_busy_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Receiver: mid-bit sampling, parity and stop check
	// ------------------------------------------------------------------
	logic rx_prev_r, rx_act_r;
	logic [14:0] rx_tick_r;
	logic rx_phase_r;
	logic [3:0] rx_idx_r;
	logic [11:0] rx_bits_r;
	wire [3:0] rx_last = nbits + {3'b000, fmt.pen} + 4'h1;
	wire rx_tick = rx_tick_r == 15'h0001;
	wire rx_sample = rx_act_r & rx_tick & ~rx_phase_r;
	wire [7:0] rx_data = rx_bits_r[8:1] & wl_mask(fmt.wl);
	wire rx_par_bit = rx_bits_r[nbits + 4'h1];
	wire rx_stop_bit = rx_bits_r[rx_last];
	assign rx_done = rx_sample & (rx_idx_r == rx_last);
	assign rx_entry.data = rx_data;
	assign rx_entry.par_err = fmt.pen &
		(rx_par_bit != par_of(rx_data, fmt)); // [RL10]
	assign rx_entry.frm_err = ~rx_in;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_prev_r <= 1'b1;
			rx_act_r <= 1'b0;
			rx_tick_r <= 15'h0001;
			rx_phase_r <= 1'b0;
			rx_idx_r <= 4'h0;
			rx_bits_r <= 12'hfff;
		end
		else if (ce)
		begin
			rx_prev_r <= rx_in;
			if (!rx_act_r)
			begin
				if (rx_prev_r && !rx_in)
				begin
					rx_act_r <= 1'b1;
					rx_tick_r <= half_div;
					rx_phase_r <= 1'b0;
					rx_idx_r <= 4'h0;
				end
			end
			else
			begin
				rx_tick_r <= rx_tick ? half_div : rx_tick_r - 15'h0001;
				if (rx_tick)
					rx_phase_r <= ~rx_phase_r;
				if (rx_sample)
				begin
					rx_bits_r[rx_idx_r] <= rx_in;
					rx_idx_r <= rx_idx_r + 4'h1;
					// A start bit gone high was a glitch
					if ((rx_idx_r == 4'h0 && rx_in) || rx_done)
						rx_act_r <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			fifo_en_r <= 1'b0; // [RL1]
			rx_code_r <= 2'b00;
			tx_code_r <= 2'b00;
			feat_r <= ufl_pkg::RST_BYTE;
			lcr_r <= ufl_pkg::RST_BYTE; // [RL7]
			div_lo_r <= ufl_pkg::RST_DIV_LO;
			div_hi_r <= ufl_pkg::RST_BYTE;
			div_fr_r <= ufl_pkg::RST_BYTE;
			rx_trig_reg_r <= ufl_pkg::TRIG_ONE;
			tx_trig_reg_r <= ufl_pkg::TRIG_ONE;
			irq_en_r <= '0;
		end
		else if (ce)
		begin
			if (w_fcr)
				fifo_en_r <= fcr_en; // [RL1]
			if (w_fcr && fcr_en)
			begin
				rx_code_r <= pwdata[7:6]; // [RL2] [RL15]
				tx_code_r <= pwdata[5:4]; // [RL2]
			end
			if (w_feat)
				feat_r <= pwdata[7:0]; // [RL13]
			if (wr && a_line)
				lcr_r <= pwdata[7:0];
			if (w_dll)
				div_lo_r <= pwdata[7:0];
			if (w_dlm)
				div_hi_r <= pwdata[7:0];
			if (w_dld)
				div_fr_r <= pwdata[7:0];
			if (wr && a_rxtg)
				rx_trig_reg_r <= pwdata[6:0]; // [RL5]
			if (wr && a_txtg)
				tx_trig_reg_r <= pwdata[6:0]; // [RL5]
			if (wr && a_ien)
				irq_en_r <= pwdata[IRQ_N_W-1:0];
		end
	end

	// ------------------------------------------------------------------
	// Interrupt events, sticky status, set beats clear
	// ------------------------------------------------------------------
	logic rx_above_r, tx_below_r;
	wire rx_above = rx_lvl_r >= rx_trig_eff; // [RL15]
	wire tx_below = tx_lvl_r < tx_trig_eff; // [RL15]
	wire [IRQ_N_W-1:0] ev = {rx_done & ~rx_push_ok,
		rx_push & rx_entry.frm_err, rx_push & rx_entry.par_err,
		tx_below & ~tx_below_r, rx_above & ~rx_above_r};
	wire [IRQ_N_W-1:0] clr = (wr && a_icl) ? pwdata[IRQ_N_W-1:0] : '0;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rx_above_r <= 1'b0;
			tx_below_r <= 1'b1;
			irq_stat_r <= '0;
			irq_r <= 1'b0;
		end
		else if (ce)
		begin
			rx_above_r <= rx_above;
			tx_below_r <= tx_below;
			irq_stat_r <= (irq_stat_r & ~clr) | ev;
			irq_r <= |(((irq_stat_r & ~clr) | ev) & irq_en_r);
		end
	end

	// ------------------------------------------------------------------
	// Read mux and bus answer, one wait state
	// ------------------------------------------------------------------
	wire [31:0] stat_val = {12'h000, rx_head.frm_err, rx_head.par_err,
		tx_busy_r, fifo_en_r, 1'b0, tx_lvl_r, 1'b0, rx_lvl_r};
	wire [7:0] fcr_view = {rx_code_r, tx_code_r, 3'b000, fifo_en_r};
	wire [31:0] rd_val =
		a_data ? {24'h0, dlab ? div_lo_r :
			(rx_lvl_r != 7'h00 ? rx_head.data : 8'h00)} :
		a_feat ? {24'h0, dlab ? div_hi_r : feat_r} :
		a_fifo ? {24'h0, dlab ? div_fr_r : fcr_view} :
		a_line ? {24'h0, lcr_r} :
		a_rxtg ? {25'h0, rx_trig_reg_r} :
		a_txtg ? {25'h0, tx_trig_reg_r} :
		a_stat ? stat_val :
		a_ist ? {27'h0, irq_stat_r} :
		a_ien ? {27'h0, irq_en_r} : 32'h0;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
			tx_out_r <= 1'b1;
		end
		else if (ce)
		begin
			pready_r <= acc;
			pslverr_r <= acc & ~mapped;
			if (rd)
				prdata_r <= rd_val;
			tx_out_r <= tx_frame_r[0] & ~lcr_r[ufl_pkg::LC_BRK]; // [RL7]
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign tx_out = tx_out_r;
	assign irq = irq_r;
endmodule
`default_nettype wire

// file: ufl_pkg.sv
// Constants and types for the serial channel FIFO and line format block
// Summary of operation
// RL1 - FIFOs off after reset; enable bit enables both
// RL2 - Other FIFO fields load only with enable set
// RL3 - Tables 00 and 01 give fixed trigger levels
// RL4 - Table 10 gives receive 8/16/56/60, transmit 8/16/32/56
// RL5 - Table 11 takes levels from trigger registers
// RL6 - Divisor access bit swaps data for divisors
// RL7 - Break bit holds transmit line low
// RL8 - Enable, even, force bits select parity
// RL9 - Unforced parity makes ones odd or even
// RL10 - Transmit appends parity; receive checks it
// RL11 - Stop select gives 1, 1.5 or 2 bits
// RL12 - Word length bits select 5 to 8 bits
// RL13 - One table select governs both directions
// RL14 - FIFO resets act only with enable, self-clear
// RL15 - Trigger fields hold; comparators use live levels
`default_nettype none
package ufl_pkg;
	// ------------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_FEAT = 8'h04;
	localparam logic [7:0] ADDR_FIFO = 8'h08;
	localparam logic [7:0] ADDR_LINE = 8'h0c;
	localparam logic [7:0] ADDR_RXTRIG = 8'h10;
	localparam logic [7:0] ADDR_TXTRIG = 8'h14;
	localparam logic [7:0] ADDR_STAT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h1c;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h20;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h24;
	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int FC_EN = 0;
	localparam int FC_RXRST = 1;
	localparam int FC_TXRST = 2;
	localparam int LC_PEN = 3;
	localparam int LC_EVEN = 4;
	localparam int LC_FORCE = 5;
	localparam int LC_BRK = 6;
	localparam int LC_DLAB = 7;
	localparam int LC_STOP = 2;
	localparam int IRQ_N = 5;
	// ------------------------------------------------------------------
	// Reset values, sizes, trigger tables
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_DIV_LO = 8'h01;
	localparam int FIFO_DEPTH = 64;
	localparam logic [6:0] FIFO_CAP = 7'h40;
	localparam logic [6:0] HOLD_CAP = 7'h01;
	localparam logic [1:0] TBL_A = 2'h0;
	localparam logic [1:0] TBL_B = 2'h1;
	localparam logic [1:0] TBL_C = 2'h2;
	localparam logic [6:0] RX_TBL_A [4] = '{7'h01, 7'h04, 7'h08, 7'h0e};
	localparam logic [6:0] RX_TBL_B [4] = '{7'h08, 7'h10, 7'h18, 7'h1c};
	localparam logic [6:0] TX_TBL_B [4] = '{7'h10, 7'h08, 7'h18, 7'h1e};
	localparam logic [6:0] RX_TBL_C [4] = '{7'h08, 7'h10, 7'h38, 7'h3c};
	localparam logic [6:0] TX_TBL_C [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
	localparam logic [6:0] TRIG_ONE = 7'h01;
	// Stop length in half-bit units
	localparam logic [4:0] STOP_HALF_1 = 5'h02;
	localparam logic [4:0] STOP_HALF_15 = 5'h03;
	localparam logic [4:0] STOP_HALF_2 = 5'h04;
	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic frm_err;
		logic par_err;
		logic [7:0] data;
	} ufl_rx_entry_t;
	typedef struct packed {
		logic pen;
		logic even;
		logic force_par;
		logic two_stop;
		logic [1:0] wl;
	} ufl_fmt_t;
endpackage
`default_nettype wire

// file: ufl_top_chk.sv
// Concurrent checks on the channel's bus, line and interrupt pins
`default_nettype none
module ufl_top_chk (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_in,
	input wire logic tx_out,
	input wire logic irq
);
	// ------
	// Shadow of host-written state
	// ------
	logic [7:0] lcr_r;
	logic [7:0] div_r;
	logic [3:0] fc_r;
	logic fen_r;
	logic brk_r;
	logic [4:0] en_r;
	logic [4:0] en_old_r;
	wire logic wr_ok = psel && penable && pready && pwrite;
	wire logic rd_ok = psel && penable && pready && !pwrite;
	wire logic dlab = lcr_r[ufl_pkg::LC_DLAB];
	wire logic bad_addr = paddr > 8'h24 || paddr[1:0] != 2'h0;
	wire logic fc_wr = wr_ok && !dlab && paddr == ufl_pkg::ADDR_FIFO;
	wire logic rd_stat = rd_ok && paddr == ufl_pkg::ADDR_STAT;
	wire logic rd_fifo = rd_ok && !dlab && paddr == ufl_pkg::ADDR_FIFO;
	wire logic rd_div = rd_ok && dlab && paddr == ufl_pkg::ADDR_DATA;
	wire logic rd_line = rd_ok && paddr == ufl_pkg::ADDR_LINE;
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			lcr_r <= 8'h00;
			div_r <= ufl_pkg::RST_DIV_LO;
			fc_r <= 4'h0;
			fen_r <= 1'b0;
			brk_r <= 1'b0;
			en_r <= 5'h00;
			en_old_r <= 5'h00;
		end
		else
		begin
			if (wr_ok && paddr == ufl_pkg::ADDR_LINE)
				lcr_r <= pwdata[7:0];
			if (wr_ok && dlab && paddr == ufl_pkg::ADDR_DATA)
				div_r <= pwdata[7:0];
			if (fc_wr)
				fen_r <= pwdata[ufl_pkg::FC_EN];
			// Codes load only alongside the enable bit
			if (fc_wr && pwdata[ufl_pkg::FC_EN])
				fc_r <= pwdata[7:4];
			if (wr_ok && paddr == ufl_pkg::ADDR_IRQ_EN)
				en_r <= pwdata[4:0];
			brk_r <= lcr_r[ufl_pkg::LC_BRK];
			en_old_r <= en_r;
		end
	end
	// ------
	// Assertions
	// ------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	sequence s_take;
		psel && penable && !pready && ce;
	endsequence
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	chk_answer_next: assert property (s_take |=> s_answer)
		else $error("bus answer timing wrong");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	chk_err_unmapped: assert property ((pready || pslverr) |->
		pready && pslverr == bad_addr)
		else $error("error response wrong");
	chk_fifo_enable: assert property (rd_stat |-> prdata[16] == fen_r)
		else $error("fifo enable status wrong");
	chk_codes_need_en: assert property (rd_fifo |->
		prdata == {24'h0, fc_r, 3'h0, fen_r})
		else $error("fifo control readback wrong");
	chk_divisor_access: assert property (rd_div |->
		prdata == {24'h0, div_r})
		else $error("divisor readback wrong");
	chk_break_low: assert property (lcr_r[ufl_pkg::LC_BRK] && brk_r
		|-> !tx_out)
		else $error("break not on line");
	chk_line_readback: assert property (rd_line |->
		prdata == {24'h0, lcr_r})
		else $error("line format readback wrong");
	chk_irq_masked: assert property (en_r == 5'h0 && en_old_r == 5'h0
		|-> !irq)
		else $error("masked interrupt raised");
endmodule
bind ufl_top ufl_top_chk CHK (.sys_clk(sys_clk), .rst(rst), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rx_in(rx_in), .tx_out(tx_out), .irq(irq));
`default_nettype wire

// file: ufl_remote.sv
// Far-end serial transceiver model on the channel's line pins
`default_nettype none
module ufl_remote (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int bitc = 4;
	int wl = 8;
	logic pen = 1'b0;
	logic [1:0] pmode = 2'h0;
	int cyc = 0;
	initial line_out = 1'b1;
	always @(posedge clk)
		cyc <= cyc + 1;
	function automatic logic par(input logic [7:0] d, input int n,
		input logic [1:0] m);
		logic x;
		x = ^(d & ((8'h1 << n) - 8'h1));
		return m[1] ? !m[0] : x ^ !m[0];
	endfunction
	task automatic put(input logic b);
		line_out <= b;
		repeat (bitc) @(posedge clk);
	endtask
	// Line rests at mark after the stop bit
	task automatic send(input logic [7:0] d, input logic bad);
		@(posedge clk);
		put(1'b0);
		for (int i = 0; i < wl; i++)
			put(d[i]);
		if (pen)
			put(par(d, wl, pmode) ^ bad);
		put(1'b1);
	endtask
	// Samples mid-bit; start time stamped for spacing checks
	task automatic recv(output logic [7:0] d, output logic p, output int t);
		int n;
		n = 0;
		d = 8'h00;
		p = 1'b0;
		while (line_in !== 1'b1 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		while (line_in !== 1'b0 && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000)
		begin
			tb_top.failures++;
			tb_top.summarize();
		end
		t = cyc;
		repeat (bitc / 2) @(posedge clk);
		for (int i = 0; i < wl; i++)
		begin
			repeat (bitc) @(posedge clk);
			d[i] = line_in;
		end
		if (pen)
		begin
			repeat (bitc) @(posedge clk);
			p = line_in;
		end
	endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench: bus tasks, far-end model, reference queue
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rx_in;
	logic tx_out;
	logic irq;
	int failures = 0;
	int compares = 0;
	logic [31:0] seed = 32'h531f;
	logic [31:0] rd;
	logic err;
	logic [7:0] rxq [$];
	ufl_top DUT (.sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out), .irq(irq));
	ufl_remote PEER (.clk(sys_clk), .line_in(tx_out), .line_out(rx_in));
	initial
		forever
			#5 sys_clk = ~sys_clk;
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic summarize();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Request held until ready is sampled high
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			failures++;
			summarize();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input string what, input logic [7:0] a,
		input logic [31:0] mask, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		cmp(what, exp, rd & mask);
	endtask
	// Trigger flag must rise on the n-th character only
	task automatic rx_trig(input int n);
		wr(ufl_pkg::ADDR_IRQ_CLR, 32'h1f);
		for (int i = 0; i < n; i++)
		begin
			rxq.push_back(rnd());
			PEER.send(rxq[$], 1'b0);
			repeat (3) @(posedge sys_clk);
			rdc("rx trigger", ufl_pkg::ADDR_IRQ_STAT, 32'h1, {31'h0, i == n - 1});
		end
	endtask
	initial
	begin
		logic [7:0] d [2];
		logic [7:0] g [2];
		logic p [2];
		int t [2];
		int w;
		int gap;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		rdc("fifo on", ufl_pkg::ADDR_STAT, 32'h10000, 32'h0);
		rdc("line fmt", ufl_pkg::ADDR_LINE, 32'hff, 32'h0);
		wr(ufl_pkg::ADDR_FIFO, 32'hf6);
		rdc("fifo codes", ufl_pkg::ADDR_FIFO, 32'hff, 32'h0);
		wr(ufl_pkg::ADDR_LINE, 32'h80);
		wr(ufl_pkg::ADDR_DATA, 32'h4);
		rdc("divisor", ufl_pkg::ADDR_DATA, 32'hff, 32'h4);
		wr(ufl_pkg::ADDR_LINE, 32'h03);
		wr(ufl_pkg::ADDR_FIFO, 32'h43);
		rdc("fifo codes", ufl_pkg::ADDR_FIFO, 32'hff, 32'h41);
		rdc("fifo on", ufl_pkg::ADDR_STAT, 32'h10000, 32'h10000);
		bus(1'b0, 8'h30, 32'h0);
		cmp("unmapped err", 32'h1, {31'h0, err});
		for (int m = 0; m < 5; m++)
		begin
			w = (m > 3) ? 3 : m;
			PEER.wl = 5 + w;
			PEER.pen = (m < 4);
			wr(ufl_pkg::ADDR_LINE, {26'h0, m[1:0], PEER.pen, ~m[0], w[1:0]});
			d[0] = rnd();
			d[1] = rnd();
			fork
				begin
					PEER.recv(g[0], p[0], t[0]);
					PEER.recv(g[1], p[1], t[1]);
				end
				begin
					wr(ufl_pkg::ADDR_DATA, {24'h0, d[0]});
					wr(ufl_pkg::ADDR_DATA, {24'h0, d[1]});
				end
			join
			for (int k = 0; k < 2; k++)
			begin
				cmp("tx data", {24'h0, d[k] & (8'hff >> (3 - w))}, {24'h0, g[k]});
				if (m < 4)
					cmp("tx parity", {31'h0, PEER.par(d[k], 5 + w, m[1:0])}, {31'h0, p[k]});
			end
			gap = 4 * (6 + w + (m < 4)) + (m[0] ? 4 : (w == 0 ? 6 : 8));
			cmp("tx spacing", 32'h1, {31'h0, t[1] - t[0] >= gap && t[1] - t[0] <= gap + 3});
			repeat (12) @(posedge sys_clk);
		end
		wr(ufl_pkg::ADDR_LINE, 32'h43);
		repeat (2) @(posedge sys_clk);
		cmp("break", 32'h0, {31'h0, tx_out});
		wr(ufl_pkg::ADDR_LINE, 32'h03);
		repeat (2) @(posedge sys_clk);
		cmp("break off", 32'h1, {31'h0, tx_out});
		wr(ufl_pkg::ADDR_IRQ_EN, 32'h01);
		rx_trig(4);
		cmp("irq pin", 32'h1, {31'h0, irq});
		rdc("rx level", ufl_pkg::ADDR_STAT, 32'h7f, 32'(rxq.size()));
		wr(ufl_pkg::ADDR_IRQ_EN, 32'h0);
		repeat (2) @(posedge sys_clk);
		cmp("irq masked", 32'h0, {31'h0, irq});
		wr(ufl_pkg::ADDR_IRQ_CLR, 32'h1);
		rdc("irq clear", ufl_pkg::ADDR_IRQ_STAT, 32'h1, 32'h0);
		for (int k = 0; k < 2; k++)
			rdc("rx data", ufl_pkg::ADDR_DATA, 32'hff, {24'h0, rxq.pop_front()});
		wr(ufl_pkg::ADDR_FEAT, 32'hc0);
		wr(ufl_pkg::ADDR_RXTRIG, 32'h2);
		wr(ufl_pkg::ADDR_FIFO, 32'hc3);
		rxq.delete();
		rdc("rx flushed", ufl_pkg::ADDR_STAT, 32'h7f, 32'h0);
		rx_trig(2);
		wr(ufl_pkg::ADDR_FEAT, 32'h80);
		wr(ufl_pkg::ADDR_FIFO, 32'h03);
		rxq.delete();
		rx_trig(8);
		// Write stalls while the clock enable is low
		ce <= 1'b0;
		fork
			wr(ufl_pkg::ADDR_LINE, 32'h0b);
			begin
				repeat (6) @(posedge sys_clk);
				cmp("frozen bus", 32'h0, {31'h0, pready});
				ce <= 1'b1;
			end
		join
		rdc("line fmt", ufl_pkg::ADDR_LINE, 32'hff, 32'h0b);
		PEER.pen = 1'b1;
		PEER.pmode = 2'h0;
		for (int k = 0; k < 2; k++)
		begin
			PEER.send(rnd(), k[0]);
			repeat (3) @(posedge sys_clk);
			rdc("rx parity", ufl_pkg::ADDR_IRQ_STAT, 32'h4, {29'h0, k[0], 2'h0});
		end
		summarize();
	end
endmodule
`default_nettype wire
